/* shared/lag_consts.svh */
// Purpose: Offsets, field positions and constants of the locality access gate
// Assumes: 12-bit register offset inside one locality window, byte-wide data
// Notes:   Definitions only
`ifndef LAG_CONSTS_SVH
`define LAG_CONSTS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define LAG_OFS_ACCESS    12'h000
`define LAG_OFS_INT_EN    12'h008
`define LAG_OFS_INT_VEC   12'h00c
`define LAG_OFS_INT_STS   12'h010
`define LAG_OFS_CAPAB     12'h014
`define LAG_OFS_STS_LO    12'h018
`define LAG_OFS_STS_HI    12'h01b
`define LAG_OFS_FIFO      12'h024
`define LAG_OFS_HASH_END  12'h020
`define LAG_OFS_HASH_DAT  12'h024
`define LAG_OFS_HASH_BEG  12'h028
`define LAG_OFS_CFG_LO    12'hf00
`define LAG_OFS_CFG_HI    12'hfff

// ************************************************************
// Localities, fields and fixed values
// ************************************************************
`define LAG_LOC_HASH      3'h4
`define LAG_LOC_LAST_STD  3'h3
`define LAG_ACC_REQ_BIT   1
`define LAG_ACC_REL_BIT   5
`define LAG_BLOCKED_DATA  8'hff
`define LAG_RESET_LOC     3'h0

`endif

/* shared/lag_pkg.sv */
// Purpose: Types of the locality access gate
// Assumes: Constants come from lag_consts.svh
// Notes:   Structs carry one host access and its outcome
package lag_pkg;

  typedef enum logic [3:0] {
    LAG_CL_NONE, LAG_CL_ACCESS, LAG_CL_INT_EN, LAG_CL_INT_VEC, LAG_CL_INT_STS,
    LAG_CL_CAPAB, LAG_CL_STS, LAG_CL_FIFO, LAG_CL_CFG,
    LAG_CL_HASH_BEG, LAG_CL_HASH_DAT, LAG_CL_HASH_END
  } lag_class_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  loc;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } lag_req_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
  } lag_rsp_type;

  typedef struct packed {
    logic        access;
    logic        sts;
    logic        fifo;
    logic        int_en;
    logic        int_vec;
    logic        int_clr;
    logic        cfg;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } lag_wr_type;

  typedef struct packed {
    logic        beg;
    logic        dat;
    logic        fin;
    logic [7:0]  wdata;
  } lag_hash_type;

  typedef struct packed {
    logic        valid;
    logic [2:0]  loc;
  } lag_active_type;

endpackage

/* hw/lag_decode.sv */
// Purpose: Map a locality and offset to a register class
// Assumes: Hash registers exist only in the locality 4 window
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "lag_consts.svh"
module lag_decode
  import lag_pkg::*;
(
  input  wire logic [2:0]    loc_in,
  input  wire logic [11:0]   addr_in,
  output lag_class_type      class_out
);
  wire is_hash_loc = (loc_in == `LAG_LOC_HASH);
  wire is_std_loc  = (loc_in <= `LAG_LOC_LAST_STD);
  wire in_sts      = (addr_in >= `LAG_OFS_STS_LO) && (addr_in <= `LAG_OFS_STS_HI);
  wire in_cfg      = (addr_in >= `LAG_OFS_CFG_LO) && (addr_in <= `LAG_OFS_CFG_HI);

  // Locality 4 only reaches the hash registers
  assign class_out =
    is_hash_loc ? ((addr_in == `LAG_OFS_HASH_BEG) ? LAG_CL_HASH_BEG :
                   (addr_in == `LAG_OFS_HASH_DAT) ? LAG_CL_HASH_DAT :
                   (addr_in == `LAG_OFS_HASH_END) ? LAG_CL_HASH_END : LAG_CL_NONE) :
    !is_std_loc ? LAG_CL_NONE :
    (addr_in == `LAG_OFS_ACCESS)  ? LAG_CL_ACCESS  :
    (addr_in == `LAG_OFS_INT_EN)  ? LAG_CL_INT_EN  :
    (addr_in == `LAG_OFS_INT_VEC) ? LAG_CL_INT_VEC :
    (addr_in == `LAG_OFS_INT_STS) ? LAG_CL_INT_STS :
    (addr_in == `LAG_OFS_CAPAB)   ? LAG_CL_CAPAB   :
    (addr_in == `LAG_OFS_FIFO)    ? LAG_CL_FIFO    :
    in_sts ? LAG_CL_STS : in_cfg ? LAG_CL_CFG : LAG_CL_NONE;
endmodule

/* hw/lag_abort_det.sv */
// Purpose: Flag a change of the active locality during command execution
// Assumes: Active locality changes only on clock edges
// Notes:   Combinational flag, registered by the caller
`timescale 1ns/1ps
module lag_abort_det
  import lag_pkg::*;
(
  input  wire logic           mclk_in,
  input  wire logic           arst_n_in,
  input  lag_active_type      active_in,
  input  wire logic           cmd_exec_in,
  output logic                change_out
);
  lag_active_type prev_q;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= active_in;
    end
  end

  // Compare against last cycle so a change is seen exactly once
  assign change_out = cmd_exec_in && (prev_q != active_in);
endmodule

/* hw/lag_gate.sv */
// Purpose: Locality gating of host accesses to the interface register set
// Assumes: Register file answers reads combinationally on req_in.addr
// Notes:   One request per cycle, answered on the next edge
//
// Contract
// - Abort the executing command whenever the active locality changes.
// - Ordinary register gating covers localities 0 to 3; locality 4 only hash.
// - Active locality reading the data FIFO gets genuine response data.
// - Active locality writes reach data FIFO and status register.
// - Non-active locality: status and FIFO read FFh, writes discarded.
// - Access and capability registers read true from localities 0 to 3; access writable.
// - Interrupt and configuration registers readable by localities 0 to 3, writable by active only.
// - Active write to interrupt status clears indications, not stores.
// - Hash start accepted when none or locality 4 active; sets locality 4.
// - Hash data and end only while 4 active; end releases; reads FFh.
`timescale 1ns/1ps
`include "lag_consts.svh"
module lag_gate
  import lag_pkg::*;
(
  input  wire logic           mclk_in,
  input  wire logic           arst_n_in,
  input  lag_req_type         req_in,
  input  wire logic [7:0]     reg_rdata_in,
  input  wire logic           cmd_exec_in,
  output lag_rsp_type         rsp_out,
  output lag_wr_type          wr_out,
  output lag_hash_type        hash_out,
  output lag_active_type      active_out,
  output logic                abort_out
);

  // ************************************************************
  // Decode
  // ************************************************************
  lag_class_type cls;
  lag_active_type act_q;
  lag_active_type act_d;
  logic          loc_change;

  lag_decode u_decode (
    .loc_in    (req_in.loc),
    .addr_in   (req_in.addr),
    .class_out (cls)
  );

  wire rd        = req_in.valid && !req_in.write;
  wire wr        = req_in.valid && req_in.write;
  wire is_active = act_q.valid && (act_q.loc == req_in.loc);
  wire none_act  = !act_q.valid;
  wire hash_act  = act_q.valid && (act_q.loc == `LAG_LOC_HASH);

  // Registers that follow the active locality for both read and write
  wire cls_owned = (cls == LAG_CL_STS) || (cls == LAG_CL_FIFO);
  // Registers readable by any of localities 0 to 3
  wire cls_open  = (cls == LAG_CL_ACCESS) || (cls == LAG_CL_CAPAB) ||
                   (cls == LAG_CL_INT_EN) || (cls == LAG_CL_INT_VEC) ||
                   (cls == LAG_CL_INT_STS) || (cls == LAG_CL_CFG);
  // Hash registers and unmapped offsets never reveal data
  wire rd_true   = rd && (cls_open || (cls_owned && is_active));

  // ************************************************************
  // Write steering
  // ************************************************************
  wire w_sts     = wr && is_active && (cls == LAG_CL_STS);
  wire w_fifo    = wr && is_active && (cls == LAG_CL_FIFO);
  wire w_int_en  = wr && is_active && (cls == LAG_CL_INT_EN);
  wire w_int_vec = wr && is_active && (cls == LAG_CL_INT_VEC);
  wire w_int_clr = wr && is_active && (cls == LAG_CL_INT_STS);
  wire w_cfg     = wr && is_active && (cls == LAG_CL_CFG);
  wire w_access  = wr && (cls == LAG_CL_ACCESS);
  wire h_beg     = wr && (cls == LAG_CL_HASH_BEG) && (none_act || hash_act);
  wire h_dat     = wr && (cls == LAG_CL_HASH_DAT) && hash_act;
  wire h_fin     = wr && (cls == LAG_CL_HASH_END) && hash_act;

  wire acc_req   = w_access && req_in.wdata[`LAG_ACC_REQ_BIT];
  wire acc_rel   = w_access && req_in.wdata[`LAG_ACC_REL_BIT] && is_active;

  // ************************************************************
  // Active locality
  // ************************************************************
  // Release wins over a grant in the same write, so a locality cannot
  // relinquish and reclaim in one access.
  always_comb begin
    act_d = act_q;
    if (h_fin || acc_rel) begin
      act_d.valid = 1'b0;
    end else if (h_beg && none_act) begin
      act_d.valid = 1'b1;
      act_d.loc   = `LAG_LOC_HASH;
    end else if (acc_req && none_act) begin
      act_d.valid = 1'b1;
      act_d.loc   = req_in.loc;
    end
  end

  lag_abort_det u_abort (
    .mclk_in     (mclk_in),
    .arst_n_in   (arst_n_in),
    .active_in   (act_q),
    .cmd_exec_in (cmd_exec_in),
    .change_out  (loc_change)
  );

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_q     <= '{valid: 1'b0, loc: `LAG_RESET_LOC};
      rsp_out   <= '0;
      wr_out    <= '0;
      hash_out  <= '0;
      abort_out <= 1'b0;
    end else begin
      act_q             <= act_d;
      rsp_out.valid     <= rd;
      rsp_out.rdata     <= rd_true ? reg_rdata_in : `LAG_BLOCKED_DATA;
      wr_out.access     <= w_access;
      wr_out.sts        <= w_sts;
      wr_out.fifo       <= w_fifo;
      wr_out.int_en     <= w_int_en;
      wr_out.int_vec    <= w_int_vec;
      wr_out.int_clr    <= w_int_clr;
      wr_out.cfg        <= w_cfg;
      wr_out.addr       <= req_in.addr;
      wr_out.wdata      <= req_in.wdata;
      hash_out.beg      <= h_beg;
      hash_out.dat      <= h_dat;
      hash_out.fin      <= h_fin;
      hash_out.wdata    <= req_in.wdata;
      abort_out         <= loc_change;
    end
  end

  assign active_out = act_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  a_abort_on_change: assert property (
    (cmd_exec_in && $changed(act_q)) |=> abort_out)
    else $error("Locality change during command did not abort");

  a_abort_cause: assert property (
    abort_out |-> $past(cmd_exec_in) && ($past(act_q, 2) != $past(act_q)))
    else $error("Abort without locality change");

  a_loc4_no_std: assert property (
    (wr && req_in.loc == `LAG_LOC_HASH) |=> !(wr_out.sts || wr_out.fifo || wr_out.access
                                             || wr_out.int_en || wr_out.cfg))
    else $error("Locality 4 reached an ordinary register");

  a_fifo_read_true: assert property (
    (rd && is_active && cls == LAG_CL_FIFO) |=> rsp_out.rdata == $past(reg_rdata_in))
    else $error("Active FIFO read not returning data");

  a_owned_write: assert property (
    (wr && is_active && (cls == LAG_CL_STS || cls == LAG_CL_FIFO))
      |=> (wr_out.sts || wr_out.fifo) && wr_out.wdata == $past(req_in.wdata))
    else $error("Active status or FIFO write dropped");

  a_foreign_blocked: assert property (
    (req_in.valid && !is_active && cls_owned)
      |=> !wr_out.sts && !wr_out.fifo && (!rsp_out.valid || rsp_out.rdata == 8'hff))
    else $error("Non-active locality reached status or FIFO");

  a_open_read: assert property (
    (rd && (cls == LAG_CL_ACCESS || cls == LAG_CL_CAPAB))
      |=> rsp_out.valid && rsp_out.rdata == $past(reg_rdata_in))
    else $error("Access or capability read gated");

  a_intr_write_gate: assert property (
    (wr && !is_active && (cls == LAG_CL_INT_EN || cls == LAG_CL_CFG))
      |=> !wr_out.int_en && !wr_out.cfg)
    else $error("Non-active write reached interrupt or config");

  a_int_clear: assert property (
    (wr && is_active && cls == LAG_CL_INT_STS)
      |=> wr_out.int_clr && !wr_out.int_en && !wr_out.int_vec && !wr_out.cfg)
    else $error("Interrupt status write did not clear");

  a_hash_start: assert property (
    (wr && cls == LAG_CL_HASH_BEG && none_act)
      |=> hash_out.beg && act_q.valid && act_q.loc == 3'h4)
    else $error("Hash start did not claim locality 4");

  a_hash_end: assert property (
    (wr && cls == LAG_CL_HASH_END) |=> hash_out.fin == $past(hash_act)
      && (!hash_out.fin || !act_q.valid))
    else $error("Hash end mishandled");

  a_hash_read: assert property (
    (rd && (cls == LAG_CL_HASH_BEG || cls == LAG_CL_HASH_DAT || cls == LAG_CL_HASH_END))
      |=> rsp_out.rdata == 8'hff)
    else $error("Hash register read not FFh");

  // ************************************************************
  // Checks on read answers
  // ************************************************************
  // Every read is answered, so a host never waits on a gated register
  a_rsp_follows_rd: assert property (
    1'b1
      |=> rsp_out.valid == $past(rd))
    else $error("Read answer pulse out of step");

  a_no_write_rsp: assert property (
    wr
      |=> !rsp_out.valid)
    else $error("Write produced a read answer");

  a_unmapped_read: assert property (
    (rd && cls == LAG_CL_NONE)
      |=> rsp_out.rdata == `LAG_BLOCKED_DATA)
    else $error("Unmapped offset read not FFh");

  a_intr_cfg_read: assert property (
    (rd && (cls == LAG_CL_INT_EN || cls == LAG_CL_INT_VEC
            || cls == LAG_CL_INT_STS || cls == LAG_CL_CFG))
      |=> rsp_out.rdata == $past(reg_rdata_in))
    else $error("Interrupt or config read gated");

  // ************************************************************
  // Checks on write steering
  // ************************************************************
  a_wr_copy: assert property (
    wr
      |=> wr_out.addr == $past(req_in.addr) && wr_out.wdata == $past(req_in.wdata))
    else $error("Write address or data not carried");

  a_no_read_strobe: assert property (
    rd
      |=> !(wr_out.sts || wr_out.fifo || wr_out.access || wr_out.int_en
            || wr_out.int_vec || wr_out.int_clr || wr_out.cfg))
    else $error("Read raised a write strobe");

  a_active_intr_write: assert property (
    (wr && is_active && (cls == LAG_CL_INT_EN || cls == LAG_CL_INT_VEC || cls == LAG_CL_CFG))
      |=> wr_out.int_en || wr_out.int_vec || wr_out.cfg)
    else $error("Active interrupt or config write dropped");

  a_int_sts_gate: assert property (
    (wr && !is_active && cls == LAG_CL_INT_STS)
      |=> !wr_out.int_clr)
    else $error("Non-active write cleared interrupts");

  // ************************************************************
  // Checks on the active locality
  // ************************************************************
  // Claims from others are dropped, not queued, so the owner keeps its claim
  a_active_grant: assert property (
    (wr && cls == LAG_CL_ACCESS && req_in.wdata[`LAG_ACC_REQ_BIT] && none_act)
      |=> act_q.valid && act_q.loc == $past(req_in.loc))
    else $error("Access request not granted");

  a_active_release: assert property (
    (wr && is_active && cls == LAG_CL_ACCESS && req_in.wdata[`LAG_ACC_REL_BIT])
      |=> !act_q.valid)
    else $error("Access release not honoured");

  a_grant_busy: assert property (
    (wr && cls == LAG_CL_ACCESS && act_q.valid && !is_active)
      |=> act_q == $past(act_q))
    else $error("Foreign access write moved the active locality");

  a_active_still: assert property (
    !req_in.valid
      |=> act_q == $past(act_q))
    else $error("Active locality changed without a request");

  a_no_abort_idle: assert property (
    !cmd_exec_in
      |=> !abort_out)
    else $error("Abort raised with no command running");

  // ************************************************************
  // Checks on the hash registers
  // ************************************************************
  a_hash_again: assert property (
    (wr && cls == LAG_CL_HASH_BEG && hash_act)
      |=> hash_out.beg && act_q == $past(act_q))
    else $error("Repeated hash start mishandled");

  a_hash_blocked: assert property (
    (wr && cls == LAG_CL_HASH_BEG && act_q.valid && !hash_act)
      |=> !hash_out.beg && act_q == $past(act_q))
    else $error("Hash start taken while another locality active");

  a_hash_data: assert property (
    (wr && cls == LAG_CL_HASH_DAT && hash_act)
      |=> hash_out.dat && hash_out.wdata == $past(req_in.wdata))
    else $error("Hash data write dropped");

  a_hash_ignored: assert property (
    (wr && !hash_act && (cls == LAG_CL_HASH_DAT || cls == LAG_CL_HASH_END))
      |=> !hash_out.dat && !hash_out.fin)
    else $error("Hash data or end taken without locality 4");

endmodule

/* bench/lag_host_model.sv */
// Purpose: Host bus controller and register file stand-in for the gate
// Assumes: Requests change at the falling edge, one access per call
// Notes:   Read data is ff only where the low offset byte is c3 xor loc, which no read uses, so a blocked read cannot pass for a true one
`timescale 1ns/1ps
module lag_host_model
  import lag_pkg::*;
(
  input  wire logic        mclk_in,
  output lag_req_type      req_out,
  output logic [7:0]       rdata_out
);
  assign rdata_out = req_out.addr[7:0] ^ {5'h00, req_out.loc} ^ 8'h3c;

  initial req_out = '0;

  task automatic access(input logic wr, input logic [2:0] loc,
                        input logic [11:0] addr, input logic [7:0] data);
    @(negedge mclk_in);
    req_out = '{valid: 1'b1, write: wr, loc: loc, addr: addr, wdata: data};
    @(negedge mclk_in);
    // Released lines show the inverse, not a stale copy
    req_out.valid = 1'b0;
    req_out.addr = ~addr;
    req_out.wdata = ~data;
  endtask
endmodule

/* bench/locality_access_gate_tb.sv */
// Purpose: Self-checking bench of the locality access gate
// Assumes: Outputs are judged at the falling edge of the answer cycle
// Notes:   No randomness; every scenario is its own task
`timescale 1ns/1ps
module locality_access_gate_tb
  import lag_pkg::*;
;
  logic           mclk_in;
  logic           arst_n_in;
  logic           cmd_exec;
  logic           abort;
  logic [7:0]     rdata;
  lag_req_type    req;
  lag_rsp_type    rsp;
  lag_wr_type     wr;
  lag_hash_type   hash;
  lag_active_type act;
  int             bad_count = 0;
  int             n_compared = 0;

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  lag_host_model host (.mclk_in(mclk_in), .req_out(req), .rdata_out(rdata));

  lag_gate DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .req_in(req),
    .reg_rdata_in(rdata), .cmd_exec_in(cmd_exec), .rsp_out(rsp), .wr_out(wr),
    .hash_out(hash), .active_out(act), .abort_out(abort));

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(logic [2:0] loc, logic [11:0] a, logic tru);
    logic [7:0] exp;
    exp = tru ? (a[7:0] ^ {5'h00, loc} ^ 8'h3c) : 8'hff;
    host.access(1'b0, loc, a, 8'h00);
    chk("read valid", 8'(rsp.valid), 8'h01);
    chk("read data", rsp.rdata, exp);
  endtask

  task automatic wt(logic [2:0] loc, logic [11:0] a, logic [7:0] d);
    host.access(1'b1, loc, a, d);
  endtask

  task automatic t_idle;
    rd(3'h0, 12'h018, 1'b0);
    rd(3'h1, 12'h024, 1'b0);
    rd(3'h3, 12'h000, 1'b1);
    rd(3'h0, 12'h014, 1'b1);
    rd(3'h2, 12'h008, 1'b1);
    rd(3'h1, 12'hf80, 1'b1);
    wt(3'h0, 12'h024, 8'h11);
    chk("fifo", 8'(wr.fifo), 8'h00);
    wt(3'h2, 12'h008, 8'h01);
    chk("int_en", 8'(wr.int_en), 8'h00);
    wt(3'h0, 12'h010, 8'h01);
    chk("int_clr", 8'(wr.int_clr), 8'h00);
    $display("test idle done");
  endtask

  task automatic t_owned;
    wt(3'h2, 12'h000, 8'h02);
    chk("access", 8'(wr.access), 8'h01);
    chk("active", 8'(act), 8'h0a);
    rd(3'h2, 12'h024, 1'b1);
    wt(3'h2, 12'h024, 8'ha5);
    chk("fifo", 8'(wr.fifo), 8'h01);
    chk("fifo data", wr.wdata, 8'ha5);
    wt(3'h2, 12'h01b, 8'h40);
    chk("sts", 8'(wr.sts), 8'h01);
    chk("sts addr", wr.addr[7:0], 8'h1b);
    wt(3'h2, 12'h014, 8'hff);
    chk("capab", 8'(wr.access), 8'h00);
    rd(3'h1, 12'h018, 1'b0);
    wt(3'h1, 12'h018, 8'h40);
    chk("sts", 8'(wr.sts), 8'h00);
    rd(3'h1, 12'h00c, 1'b1);
    wt(3'h1, 12'h00c, 8'h05);
    chk("int_vec", 8'(wr.int_vec), 8'h00);
    wt(3'h2, 12'h00c, 8'h05);
    chk("int_vec", 8'(wr.int_vec), 8'h01);
    wt(3'h2, 12'h010, 8'h04);
    chk("int_clr", 8'(wr.int_clr), 8'h01);
    wt(3'h3, 12'hfff, 8'h07);
    chk("cfg", 8'(wr.cfg), 8'h00);
    wt(3'h2, 12'hf00, 8'h07);
    chk("cfg", 8'(wr.cfg), 8'h01);
    wt(3'h1, 12'h000, 8'h02);
    chk("access", 8'(wr.access), 8'h01);
    chk("active", 8'(act), 8'h0a);
    $display("test owned done");
  endtask

  task automatic t_abort;
    cmd_exec = 1'b1;
    wt(3'h2, 12'h000, 8'h20);
    chk("active", 8'(act.valid), 8'h00);
    @(negedge mclk_in);
    chk("abort", 8'(abort), 8'h01);
    wt(3'h0, 12'h000, 8'h02);
    chk("abort", 8'(abort), 8'h00);
    @(negedge mclk_in);
    chk("abort", 8'(abort), 8'h01);
    cmd_exec = 1'b0;
    wt(3'h0, 12'h000, 8'h20);
    @(negedge mclk_in);
    chk("abort", 8'(abort), 8'h00);
    $display("test abort done");
  endtask

  task automatic t_hash;
    rd(3'h4, 12'h028, 1'b0);
    wt(3'h4, 12'h020, 8'h00);
    chk("fin", 8'(hash.fin), 8'h00);
    wt(3'h4, 12'h024, 8'h3e);
    chk("dat", 8'(hash.dat), 8'h00);
    wt(3'h4, 12'h028, 8'h00);
    chk("beg", 8'(hash.beg), 8'h01);
    chk("active", 8'(act), 8'h0c);
    wt(3'h4, 12'h028, 8'h00);
    chk("beg", 8'(hash.beg), 8'h01);
    rd(3'h4, 12'h024, 1'b0);
    wt(3'h4, 12'h024, 8'h3e);
    chk("dat", 8'(hash.dat), 8'h01);
    chk("dat data", hash.wdata, 8'h3e);
    rd(3'h4, 12'h000, 1'b0);
    wt(3'h0, 12'h000, 8'h02);
    chk("active", 8'(act), 8'h0c);
    wt(3'h4, 12'h020, 8'h00);
    chk("fin", 8'(hash.fin), 8'h01);
    chk("active", 8'(act.valid), 8'h00);
    wt(3'h1, 12'h000, 8'h02);
    wt(3'h4, 12'h028, 8'h00);
    chk("beg", 8'(hash.beg), 8'h00);
    chk("active", 8'(act), 8'h09);
    $display("test hash done");
  endtask

  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    arst_n_in = 1'b0;
    cmd_exec = 1'b0;
    repeat (20) @(negedge mclk_in);
    arst_n_in = 1'b1;
    t_idle();
    t_owned();
    t_abort();
    t_hash();
    conclude();
  end

  // About 80 cycles of traffic after 20 of reset; the margin is generous
  initial begin
    #100us;
    bad_count++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end
endmodule
